// File: core/wwfr_top.sv
// Behaviour
// - Enabled sequencer fault pulses reset output low
// - Route bits pick watchdog faults driving reset
// - Enable bit gates response, never detection
// - Non-zero window count turns detection on
// - Every detected fault reports its status flag
// - Mask bits pick faults causing regulator shutdown
// - Rails restart per pins after 200ms
// - Select bit: all rails or low rail
// - Only supply or enable cycling clears lockout
// - Kick select picks pin edge or none; register always kicks
// - Upper timebase code selects tick or disables
// - Gap beyond tick times count: too slow
// - Restart fault at twice the too-slow period
// - Four-bit upper count enables slow, restart detection
// - Kick inside lower limit: too fast
// - Only 0x2a written to kick register kicks
`timescale 1ns/1ps
`default_nettype none
`include "wwfr_defs.svh"

module wwfr_top #(
    parameter logic [31:0] P_RST_SHORT_CYC    = `WWFR_RST_SHORT_CYC,
    parameter logic [31:0] P_RST_LONG_CYC     = `WWFR_RST_LONG_CYC,
    parameter logic [31:0] P_RESTART_WAIT_CYC = `WWFR_RESTART_WAIT_CYC
) (
    // Clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_NRST,
    // Register port
    input  wire logic        I_REG_WR,
    input  wire logic        I_REG_RD,
    input  wire logic [7:0]  I_REG_ADDR,
    input  wire logic [7:0]  I_REG_WDATA,
    output logic      [7:0]  O_REG_RDATA,
    output logic             O_REG_RVALID,
    // Kick pin
    input  wire logic        I_GPIO_IN,
    input  wire logic        I_GPIO_IS_INPUT,
    // Faults, options and enable cycling
    input  wire logic        I_SEQ_FAULT,
    input  wire logic        I_SHORT_FAULT_WAIT,
    input  wire logic        I_EN_CYCLED,
    // Regulator enable pins
    input  wire logic        I_HV_RAIL_EN_PIN,
    input  wire logic        I_LV_RAIL_EN_PIN,
    // Reset, rails and status
    output logic             O_RST_N,
    output logic             O_HV_RAIL_ON,
    output logic             O_LV_RAIL_TURN_ON,
    output logic      [2:0]  O_WDT_FAULT_SET,
    output logic             O_LOCKED
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [3:0]  route_q;
    logic        wdt_en_q;
    logic [2:0]  sd_mask_q;
    logic        sd_sel_q;
    logic        lock_q;
    logic [1:0]  kick_sel_q;
    logic [6:0]  upper_q;
    logic [6:0]  lower_q;

    logic        wr_route;
    logic        wr_cfg;
    logic        wr_upper;
    logic        wr_lower;
    logic        wr_kick;

    always_comb begin
        wr_route = 1'b0;
        wr_cfg   = 1'b0;
        wr_upper = 1'b0;
        wr_lower = 1'b0;
        wr_kick  = 1'b0;
        if (!I_REG_WR) begin
            wr_route = 1'b0;
        end else if (I_REG_ADDR == `WWFR_ADDR_RST_ROUTE) begin
            wr_route = 1'b1;
        end else if (I_REG_ADDR == `WWFR_ADDR_CFG) begin
            wr_cfg = !lock_q;
        end else if (I_REG_ADDR == `WWFR_ADDR_UPPER) begin
            wr_upper = !lock_q;
        end else if (I_REG_ADDR == `WWFR_ADDR_LOWER) begin
            wr_lower = !lock_q;
        end else if (I_REG_ADDR == `WWFR_ADDR_KICK) begin
            wr_kick = 1'b1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            route_q <= `WWFR_RST_ROUTE_RESET;
        end else if (wr_route) begin
            route_q <= I_REG_WDATA[`WWFR_ROUTE_SEQ_BIT:`WWFR_ROUTE_WDT_LO];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            wdt_en_q   <= 1'(`WWFR_CFG_RESET >> `WWFR_CFG_EN_BIT);
            sd_mask_q  <= 3'h0;
            sd_sel_q   <= 1'b0;
            kick_sel_q <= 2'h0;
        end else if (wr_cfg) begin
            wdt_en_q   <= I_REG_WDATA[`WWFR_CFG_EN_BIT];
            sd_mask_q  <= I_REG_WDATA[`WWFR_CFG_MASK_HI:`WWFR_CFG_MASK_LO];
            sd_sel_q   <= I_REG_WDATA[`WWFR_CFG_SEL_BIT];
            kick_sel_q <= I_REG_WDATA[`WWFR_CFG_KICK_HI:`WWFR_CFG_KICK_LO];
        end
    end

    // A write of zero never clears the lockout; only a power or enable cycle does.
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            lock_q <= 1'b0;
        end else if (I_EN_CYCLED) begin
            lock_q <= 1'b0;
        end else if (wr_cfg && I_REG_WDATA[`WWFR_CFG_LOCK_BIT]) begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            upper_q <= `WWFR_WIN_RESET;
            lower_q <= `WWFR_WIN_RESET;
        end else begin
            if (wr_upper) begin
                upper_q <= I_REG_WDATA[6:0];
            end
            if (wr_lower) begin
                lower_q <= I_REG_WDATA[6:0];
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_REG_RDATA  <= 8'h00;
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RD;
            if (!I_REG_RD) begin
                O_REG_RDATA <= O_REG_RDATA;
            end else if (I_REG_ADDR == `WWFR_ADDR_RST_ROUTE) begin
                O_REG_RDATA <= {4'h0, route_q};
            end else if (I_REG_ADDR == `WWFR_ADDR_CFG) begin
                O_REG_RDATA <= {wdt_en_q, sd_mask_q, sd_sel_q, lock_q, kick_sel_q};
            end else if (I_REG_ADDR == `WWFR_ADDR_UPPER) begin
                O_REG_RDATA <= {1'b0, upper_q};
            end else if (I_REG_ADDR == `WWFR_ADDR_LOWER) begin
                O_REG_RDATA <= {1'b0, lower_q};
            end else begin
                O_REG_RDATA <= 8'h00;
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_LOCKED <= 1'b0;
        end else begin
            O_LOCKED <= lock_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Kick sources.
    logic        gpio_q;
    logic        gpio_vld_q;
    logic        pin_rise;
    logic        pin_fall;
    logic        pin_kick;
    logic        reg_kick;
    logic        kick;

    // The first sample after reset only primes the edge detector.
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            gpio_q     <= 1'b0;
            gpio_vld_q <= 1'b0;
        end else begin
            gpio_q     <= I_GPIO_IN;
            gpio_vld_q <= 1'b1;
        end
    end

    // At 8 ns per sample a 25 ns high or low phase is always seen.
    assign pin_rise = gpio_vld_q && !gpio_q && I_GPIO_IN;
    assign pin_fall = gpio_vld_q && gpio_q && !I_GPIO_IN;

    always_comb begin
        pin_kick = 1'b0;
        if (I_GPIO_IS_INPUT) begin
            case (kick_sel_q)
                2'h0:    pin_kick = pin_fall;
                2'h1:    pin_kick = pin_rise;
                2'h2:    pin_kick = pin_rise;
                default: pin_kick = 1'b0;
            endcase
        end
    end

    assign reg_kick = wr_kick && (I_REG_WDATA == `WWFR_KICK_CODE);
    assign kick     = reg_kick || pin_kick;

    ////////////////////////////////////////////////////////////////////////////
    // Timebases and window counters.
    logic [`WWFR_NUM_TICKS-1:0] tick;
    logic [2:0]  up_sel;
    logic [3:0]  up_cnt;
    logic [2:0]  lo_sel;
    logic [3:0]  lo_cnt;
    logic        up_tick;
    logic        lo_tick;
    logic        up_det;
    logic        lo_det;
    logic [4:0]  up_count;
    logic [4:0]  lo_count;
    logic        win_clear;
    logic        fast_hit;
    logic        slow_hit;
    logic        restart_hit;

    assign up_sel = upper_q[`WWFR_WIN_TICK_HI:`WWFR_WIN_TICK_LO];
    assign up_cnt = upper_q[`WWFR_WIN_CNT_HI:`WWFR_WIN_CNT_LO];
    assign lo_sel = lower_q[`WWFR_WIN_TICK_HI:`WWFR_WIN_TICK_LO];
    assign lo_cnt = lower_q[`WWFR_WIN_CNT_HI:`WWFR_WIN_CNT_LO];

    always_comb begin
        up_tick = 1'b0;
        lo_tick = 1'b0;
        if ((up_sel != 3'h0) && (up_sel <= `WWFR_UPPER_TICK_MAX)) begin
            up_tick = tick[up_sel - 3'h1];
        end
        if ((lo_sel != 3'h0) && (lo_sel <= `WWFR_LOWER_TICK_MAX)) begin
            lo_tick = tick[lo_sel - 3'h1];
        end
    end

    // Detection runs on the window registers alone, whatever the enable bit says.
    assign up_det = (up_cnt != 4'h0) && (up_sel != 3'h0)
                    && (up_sel <= `WWFR_UPPER_TICK_MAX);
    assign lo_det = (lo_cnt != 4'h0) && (lo_sel != 3'h0)
                    && (lo_sel <= `WWFR_LOWER_TICK_MAX);

    // A restart fault also restarts the window so it fires once per period.
    assign win_clear = kick || restart_hit;

    wwfr_tick_gen u_tick_gen (
        .i_clk   (I_CLOCK),
        .i_nrst  (I_NRST),
        .i_clear (win_clear),
        .o_tick  (tick)
    );

    wwfr_win_cnt u_upper_cnt (
        .i_clk   (I_CLOCK),
        .i_nrst  (I_NRST),
        .i_clear (win_clear),
        .i_tick  (up_tick),
        .o_count (up_count)
    );

    wwfr_win_cnt u_lower_cnt (
        .i_clk   (I_CLOCK),
        .i_nrst  (I_NRST),
        .i_clear (win_clear),
        .i_tick  (lo_tick),
        .o_count (lo_count)
    );

    assign slow_hit    = up_det && up_tick
                         && (up_count == 5'({1'b0, up_cnt} - 5'h01));
    assign restart_hit = up_det && up_tick
                         && (up_count == 5'({up_cnt, 1'b0} - 5'h01));
    assign fast_hit    = lo_det && kick && (lo_count < {1'b0, lo_cnt});

    wwfr_pkg::wwfr_fault_vec_t faults;
    assign faults = {restart_hit, slow_hit, fast_hit};

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_WDT_FAULT_SET <= 3'h0;
        end else begin
            O_WDT_FAULT_SET <= faults;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset output pulse.
    logic        rst_hit;
    logic [31:0] rst_cnt_q;

    assign rst_hit = (wdt_en_q
                      && |(faults & route_q[`WWFR_ROUTE_WDT_HI:`WWFR_ROUTE_WDT_LO]))
                     || (I_SEQ_FAULT && route_q[`WWFR_ROUTE_SEQ_BIT]);

    // A new fault during a pulse restarts the full duration.
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            rst_cnt_q <= 32'h0000_0000;
            O_RST_N   <= 1'b1;
        end else if (rst_hit) begin
            rst_cnt_q <= (I_SHORT_FAULT_WAIT ? P_RST_SHORT_CYC : P_RST_LONG_CYC) - 32'h1;
            O_RST_N   <= 1'b0;
        end else if (rst_cnt_q != 32'h0000_0000) begin
            rst_cnt_q <= rst_cnt_q - 32'h1;
            O_RST_N   <= 1'b0;
        end else begin
            O_RST_N   <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Regulator shutdown and timed restart.
    wwfr_pkg::wwfr_sd_state_t sd_state_q;
    logic        sd_hit;
    logic        lv_only_q;
    logic [31:0] sd_cnt_q;

    assign sd_hit = wdt_en_q && |(faults & sd_mask_q);

    // Faults arriving while the rails are already cycling are not queued.
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            sd_state_q <= wwfr_pkg::WWFR_SD_IDLE;
            lv_only_q  <= 1'b0;
            sd_cnt_q   <= 32'h0000_0000;
        end else begin
            case (sd_state_q)
                wwfr_pkg::WWFR_SD_IDLE: begin
                    if (sd_hit) begin
                        sd_state_q <= wwfr_pkg::WWFR_SD_OFF;
                        lv_only_q  <= sd_sel_q;
                    end
                end
                wwfr_pkg::WWFR_SD_OFF: begin
                    sd_state_q <= wwfr_pkg::WWFR_SD_WAIT;
                    sd_cnt_q   <= P_RESTART_WAIT_CYC - 32'h1;
                end
                wwfr_pkg::WWFR_SD_WAIT: begin
                    if (sd_cnt_q == 32'h0000_0000) begin
                        sd_state_q <= wwfr_pkg::WWFR_SD_IDLE;
                    end else begin
                        sd_cnt_q <= sd_cnt_q - 32'h1;
                    end
                end
                default: begin
                    sd_state_q <= wwfr_pkg::WWFR_SD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_HV_RAIL_ON      <= 1'b0;
            O_LV_RAIL_TURN_ON <= 1'b0;
        end else if (sd_state_q != wwfr_pkg::WWFR_SD_IDLE) begin
            O_HV_RAIL_ON      <= lv_only_q && I_HV_RAIL_EN_PIN;
            O_LV_RAIL_TURN_ON <= 1'b0;
        end else begin
            O_HV_RAIL_ON      <= I_HV_RAIL_EN_PIN;
            O_LV_RAIL_TURN_ON <= I_LV_RAIL_EN_PIN;
        end
    end

endmodule // wwfr_top

`default_nettype wire

// File: core/wwfr_defs.svh
`ifndef WWFR_DEFS_SVH
`define WWFR_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets.
`define WWFR_ADDR_RST_ROUTE     8'h8d
`define WWFR_ADDR_CFG           8'ha0
`define WWFR_ADDR_UPPER         8'ha1
`define WWFR_ADDR_LOWER         8'ha2
`define WWFR_ADDR_KICK          8'ha3

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define WWFR_RST_ROUTE_RESET    4'h0
`define WWFR_CFG_RESET          8'h00
`define WWFR_WIN_RESET          7'h00

////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define WWFR_ROUTE_SEQ_BIT      3
`define WWFR_ROUTE_WDT_HI       2
`define WWFR_ROUTE_WDT_LO       0
`define WWFR_CFG_EN_BIT         7
`define WWFR_CFG_MASK_HI        6
`define WWFR_CFG_MASK_LO        4
`define WWFR_CFG_SEL_BIT        3
`define WWFR_CFG_LOCK_BIT       2
`define WWFR_CFG_KICK_HI        1
`define WWFR_CFG_KICK_LO        0
`define WWFR_WIN_TICK_HI        6
`define WWFR_WIN_TICK_LO        4
`define WWFR_WIN_CNT_HI         3
`define WWFR_WIN_CNT_LO         0

////////////////////////////////////////////////////////////////////////////////
// Codes.
`define WWFR_KICK_CODE          8'h2a
`define WWFR_UPPER_TICK_MAX     3'h6
`define WWFR_LOWER_TICK_MAX     3'h5

////////////////////////////////////////////////////////////////////////////////
// Timing.
`define WWFR_CLK_PERIOD_NS      8
`define WWFR_BASE_TICK_NS       10000
`define WWFR_BASE_TICK_CYC      (`WWFR_BASE_TICK_NS / `WWFR_CLK_PERIOD_NS)
`define WWFR_DECADE             4'h9
`define WWFR_NUM_TICKS          6
`define WWFR_RESTART_WAIT_MS    200
`define WWFR_RESTART_WAIT_CYC   (`WWFR_RESTART_WAIT_MS * 1000000 / `WWFR_CLK_PERIOD_NS)
`define WWFR_RST_SHORT_US       1000
`define WWFR_RST_SHORT_CYC      (`WWFR_RST_SHORT_US * 1000 / `WWFR_CLK_PERIOD_NS)
`define WWFR_RST_LONG_US        10000
`define WWFR_RST_LONG_CYC       (`WWFR_RST_LONG_US * 1000 / `WWFR_CLK_PERIOD_NS)

`endif

// File: core/wwfr_pkg.sv
package wwfr_pkg;

    typedef enum logic [1:0] {
        WWFR_SD_IDLE,
        WWFR_SD_OFF,
        WWFR_SD_WAIT
    } wwfr_sd_state_t;

    typedef logic [2:0] wwfr_fault_vec_t;

endpackage

// File: core/wwfr_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "wwfr_defs.svh"

module wwfr_tick_gen (
    // Clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_nrst,
    // Phase restart
    input  wire logic                         i_clear,
    // Tick pulses, bit k every 10us times ten to the k
    output logic      [`WWFR_NUM_TICKS-1:0]   o_tick
);

    logic [10:0] base_q;

    always_ff @(posedge i_clk) begin
        if (!i_nrst || i_clear) begin
            base_q <= 11'h000;
        end else if (o_tick[0]) begin
            base_q <= 11'h000;
        end else begin
            base_q <= base_q + 11'h001;
        end
    end

    assign o_tick[0] = (base_q == 11'(`WWFR_BASE_TICK_CYC - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Each decade divides the tick below it by ten.
    genvar k;
    generate
        for (k = 1; k < `WWFR_NUM_TICKS; k = k + 1) begin : g_decade
            logic [3:0] dec_q;
            always_ff @(posedge i_clk) begin
                if (!i_nrst || i_clear) begin
                    dec_q <= 4'h0;
                end else if (o_tick[k-1]) begin
                    dec_q <= (dec_q == `WWFR_DECADE) ? 4'h0 : dec_q + 4'h1;
                end
            end
            assign o_tick[k] = o_tick[k-1] && (dec_q == `WWFR_DECADE);
        end
    endgenerate

endmodule // wwfr_tick_gen

`default_nettype wire

// File: core/wwfr_win_cnt.sv
`timescale 1ns/1ps
`default_nettype none

module wwfr_win_cnt (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Control
    input  wire logic        i_clear,
    input  wire logic        i_tick,
    // Elapsed ticks since the last clear
    output logic      [4:0]  o_count
);

    // Saturates so that a late kick never wraps into a short elapsed time.
    always_ff @(posedge i_clk) begin
        if (!i_nrst || i_clear) begin
            o_count <= 5'h00;
        end else if (i_tick && (o_count != 5'h1f)) begin
            o_count <= o_count + 5'h01;
        end
    end

endmodule // wwfr_win_cnt

`default_nettype wire

// File: verification/wwfr_checker.sv
`timescale 1ns/1ps
`default_nettype none

module wwfr_checker #(
    parameter logic [31:0] P_RST_SHORT_CYC    = 32'h5,
    parameter logic [31:0] P_RST_LONG_CYC     = 32'h9,
    parameter logic [31:0] P_RESTART_WAIT_CYC = 32'h14
) (
    // Clock, reset and register writes
    input wire logic       I_CLOCK,
    input wire logic       I_NRST,
    input wire logic       I_REG_WR,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    // Fault sources and pins
    input wire logic       I_SEQ_FAULT,
    input wire logic       I_SHORT_FAULT_WAIT,
    input wire logic       I_EN_CYCLED,
    input wire logic       I_HV_RAIL_EN_PIN,
    input wire logic       I_LV_RAIL_EN_PIN,
    // Watched outputs
    input wire logic       O_RST_N,
    input wire logic       O_HV_RAIL_ON,
    input wire logic       O_LV_RAIL_TURN_ON,
    input wire logic [2:0] O_WDT_FAULT_SET,
    input wire logic       O_LOCKED
);
    logic [31:0] low_q;
    logic [31:0] off_q;
    logic [31:0] pin_q;

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_NRST);

    //////////////////////////////////////////////////
    // Run lengths: reset pulse, rail outage, pin held high.
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            low_q <= 32'h0;
            off_q <= 32'h0;
            pin_q <= 32'h0;
        end else begin
            low_q <= O_RST_N ? 32'h0 : low_q + 32'h1;
            off_q <= O_LV_RAIL_TURN_ON ? 32'h0 : off_q + 32'h1;
            pin_q <= I_LV_RAIL_EN_PIN ? pin_q + 32'h1 : 32'h0;
        end
    end

    //////////////////////////////////////////////////
    AST_RST_CAUSE: assert property (
        $fell(O_RST_N) |-> $past(I_SEQ_FAULT) || $past(I_SEQ_FAULT, 2)
            || (|O_WDT_FAULT_SET) || (|$past(O_WDT_FAULT_SET)))
        else $error("reset output fell with no fault");
    AST_RST_SHORT: assert property (
        $rose(O_RST_N) && I_SHORT_FAULT_WAIT |-> low_q >= P_RST_SHORT_CYC)
        else $error("short reset pulse too brief");
    AST_RST_LONG: assert property (
        $rose(O_RST_N) && !I_SHORT_FAULT_WAIT |-> low_q >= P_RST_LONG_CYC)
        else $error("long reset pulse too brief");
    AST_FLT_PULSE: assert property (
        (|O_WDT_FAULT_SET[2:1]) |=> !(|O_WDT_FAULT_SET[2:1]))
        else $error("fault status pulse longer than one cycle");
    AST_LOCK_SET: assert property (
        I_REG_WR && I_REG_ADDR == 8'ha0 && I_REG_WDATA[2] && !I_EN_CYCLED
            |-> ##[1:2] O_LOCKED)
        else $error("lockout not set by write");
    AST_LOCK_HOLD: assert property (
        O_LOCKED && !I_EN_CYCLED && !$past(I_EN_CYCLED) |=> O_LOCKED)
        else $error("lockout cleared without enable cycling");
    AST_LOCK_CLR: assert property (
        I_EN_CYCLED |-> ##[1:2] !O_LOCKED)
        else $error("lockout kept after enable cycling");
    AST_HV_PIN: assert property (
        O_HV_RAIL_ON |-> $past(I_HV_RAIL_EN_PIN))
        else $error("high rail on with its pin low");
    AST_LV_PIN: assert property (
        O_LV_RAIL_TURN_ON |-> $past(I_LV_RAIL_EN_PIN))
        else $error("low rail on with its pin low");
    AST_LV_WAIT: assert property (
        $rose(O_LV_RAIL_TURN_ON) && pin_q > off_q + 32'h2
            |-> off_q == P_RESTART_WAIT_CYC + 32'h1)
        else $error("low rail outage has wrong length");

endmodule // wwfr_checker

bind wwfr_top wwfr_checker #(
    .P_RST_SHORT_CYC(P_RST_SHORT_CYC),
    .P_RST_LONG_CYC(P_RST_LONG_CYC),
    .P_RESTART_WAIT_CYC(P_RESTART_WAIT_CYC)
) u_chk (.I_CLOCK, .I_NRST, .I_REG_WR, .I_REG_ADDR, .I_REG_WDATA,
    .I_SEQ_FAULT, .I_SHORT_FAULT_WAIT, .I_EN_CYCLED, .I_HV_RAIL_EN_PIN,
    .I_LV_RAIL_EN_PIN, .O_RST_N, .O_HV_RAIL_ON, .O_LV_RAIL_TURN_ON,
    .O_WDT_FAULT_SET, .O_LOCKED);

`default_nettype wire

// File: verification/wwfr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module wwfr_host_model (
    // Clock
    input  wire logic i_clk,
    // Kick pin level
    output var  logic o_gpio
);
    initial o_gpio = 1'b0;

    // Four cycles are 32 ns, so both levels outlast the 25 ns minimum.
    task automatic kick_edge(input logic rise);
        @(posedge i_clk);
        o_gpio <= ~rise;
        repeat (4) @(posedge i_clk);
        o_gpio <= rise;
        repeat (4) @(posedge i_clk);
    endtask
endmodule // wwfr_host_model

`default_nettype wire

// File: verification/wwfr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module wwfr_top_tb;
    localparam int SH = 5;
    localparam int LG = 9;
    localparam int RW = 20;
    logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic       is_in = 1'b1, seq = 1'b0, shrt = 1'b1, en_cyc = 1'b0;
    logic       hv_pin = 1'b1, lv_pin = 1'b1;
    logic [7:0] rdata;
    logic       rvalid, rst_n, hv_on, lv_on, locked, gpio;
    logic [2:0] fset;
    int         err_total = 0, total_checks = 0;
    int         nf[3], n_rst, n_hv, n_lv;
    logic [7:0] rr[4] = '{8'h8d, 8'ha0, 8'ha1, 8'ha2};
    logic [7:0] dis[3] = '{8'h02, 8'h72, 8'h10};
    logic [7:0] gc[2] = '{8'ha8, 8'h20};
    logic [7:0] sr[3] = '{8'h08, 8'h08, 8'h00};
    logic       sw[3] = '{1'b1, 1'b0, 1'b1};
    int         se[3] = '{SH, LG, 0};

    wwfr_top #(.P_RST_SHORT_CYC(SH), .P_RST_LONG_CYC(LG),
        .P_RESTART_WAIT_CYC(RW)) uut (
        .I_CLOCK(clk), .I_NRST(nrst), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .O_REG_RVALID(rvalid), .I_GPIO_IN(gpio), .I_GPIO_IS_INPUT(is_in),
        .I_SEQ_FAULT(seq), .I_SHORT_FAULT_WAIT(shrt), .I_EN_CYCLED(en_cyc),
        .I_HV_RAIL_EN_PIN(hv_pin), .I_LV_RAIL_EN_PIN(lv_pin),
        .O_RST_N(rst_n), .O_HV_RAIL_ON(hv_on), .O_LV_RAIL_TURN_ON(lv_on),
        .O_WDT_FAULT_SET(fset), .O_LOCKED(locked));
    wwfr_host_model host (.i_clk(clk), .o_gpio(gpio));

    always #4 clk = ~clk;

    // Counted mid-cycle so that clearing at a rising edge never races.
    always @(negedge clk) begin
        for (int b = 0; b < 3; b++) nf[b] += int'(fset[b] === 1'b1);
        n_rst += int'(rst_n === 1'b0);
        n_hv += int'(hv_on === 1'b0);
        n_lv += int'(lv_on === 1'b0);
    end

    //////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic clr();
        nf = '{0, 0, 0};
        n_rst = 0;
        n_hv = 0;
        n_lv = 0;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chkn(input int g, input int e);
        total_checks++;
        if (g != e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk8({7'h00, rvalid}, 8'h01);
        chk8(rdata, e);
    endtask
    task automatic kick();
        wreg(8'ha3, 8'h2a);
    endtask
    task automatic test_done();
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    //////////////////////////////////////////////////
    initial begin
        cyc(10);
        nrst <= 1'b1;
        foreach (rr[i]) rreg(rr[i], 8'h00);
        wreg(8'h8d, 8'hff);
        rreg(8'h8d, 8'h0f);
        wreg(8'ha1, 8'hff);
        rreg(8'ha1, 8'h7f);
        wreg(8'ha0, 8'hfb);
        rreg(8'ha0, 8'hfb);
        rreg(8'h55, 8'h00);
        rreg(8'ha3, 8'h00);
        wreg(8'ha0, 8'h00);
        wreg(8'h8d, 8'h07);
        wreg(8'ha1, 8'h12);
        kick();
        clr();
        cyc(2490);
        chkn(nf[1], 0);
        cyc(20);
        chkn(nf[1], 1);
        cyc(2480);
        chkn(nf[2], 0);
        cyc(20);
        chkn(nf[2], 1);
        chkn(n_rst, 0);
        foreach (dis[i]) begin
            wreg(8'ha1, dis[i]);
            kick();
            clr();
            cyc(2600);
            chkn(nf[1], 0);
        end
        wreg(8'ha1, 8'h12);
        kick();
        clr();
        cyc(2000);
        wreg(8'ha3, 8'h55);
        cyc(600);
        chkn(nf[1], 1);
        kick();
        clr();
        cyc(2000);
        kick();
        cyc(600);
        chkn(nf[1], 0);
        wreg(8'ha2, 8'h11);
        cyc(1300);
        for (int b = 0; b < 3; b++) begin
            wreg(8'h8d, 8'h01 << b);
            wreg(8'ha0, 8'h80 | (8'h10 << b));
            kick();
            clr();
            if (b == 0) kick();
            cyc(5100);
            chkn(nf[b], 1);
            chkn(n_rst, SH);
            chkn(n_hv, RW + 1);
            chkn(n_lv, RW + 1);
        end
        wreg(8'ha2, 8'h00);
        wreg(8'h8d, 8'h02);
        foreach (gc[i]) begin
            wreg(8'ha0, gc[i]);
            kick();
            clr();
            cyc(2600);
            chkn(nf[1], 1);
            chkn(n_rst, i ? 0 : SH);
            chkn(n_hv, 0);
            chkn(n_lv, i ? 0 : RW + 1);
        end
        foreach (sr[i]) begin
            wreg(8'h8d, sr[i]);
            @(posedge clk);
            shrt <= sw[i];
            seq <= 1'b1;
            @(posedge clk);
            seq <= 1'b0;
            clr();
            cyc(20);
            chkn(n_rst, se[i]);
        end
        wreg(8'h8d, 8'h00);
        hv_pin <= 1'b0;
        clr();
        cyc(7);
        hv_pin <= 1'b1;
        cyc(2);
        chkn(n_hv, 7);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            is_in <= (i < 4);
            wreg(8'ha0, (i < 4) ? 8'(i) : 8'h01);
            kick();
            clr();
            repeat (4) begin
                host.kick_edge(i != 0);
                cyc(1000);
            end
            chkn(nf[1], (i >= 3) ? 1 : 0);
        end
        is_in <= 1'b1;
        wreg(8'ha0, 8'h04);
        cyc(2);
        chk8({7'h00, locked}, 8'h01);
        wreg(8'ha1, 8'h33);
        wreg(8'ha0, 8'h00);
        rreg(8'ha1, 8'h12);
        rreg(8'ha0, 8'h04);
        kick();
        clr();
        cyc(2000);
        kick();
        cyc(2000);
        chkn(nf[1], 0);
        en_cyc <= 1'b1;
        @(posedge clk);
        en_cyc <= 1'b0;
        cyc(2);
        chk8({7'h00, locked}, 8'h00);
        wreg(8'ha1, 8'h33);
        rreg(8'ha1, 8'h33);
        wreg(8'ha0, 8'h04);
        nrst <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        rreg(8'ha0, 8'h00);
        test_done();
    end

    // The tests need about 65000 cycles; this leaves ample margin.
    initial begin
        cyc(100000);
        err_total++;
        test_done();
    end
endmodule // wwfr_top_tb

`default_nettype wire
